// ---- design/cebc_bus_ctrl.sv ----
// CPU external bus control: cycles, wait, bus hand-off, halt, reset pin
`timescale 1ns/100ps
`include "cebc_map.svh"
module cebc_bus_ctrl
#(
    parameter int ADDR_W = `CEBC_ADDR_W,
    parameter int DATA_W = `CEBC_DATA_W
)
(
    input  wire logic              ref_clk_i,
    input  wire logic              arst_n_i,
    input  wire logic              cpu_req_i,
    input  wire logic              cpu_io_i,
    input  wire logic              cpu_wr_i,
    input  wire logic              cpu_fetch_i,
    input  wire logic [ADDR_W-1:0] cpu_addr_i,
    input  wire logic [DATA_W-1:0] cpu_wdata_i,
    output logic                   cpu_done_o,
    output logic [DATA_W-1:0]      cpu_rdata_o,
    input  wire logic              cpu_halt_i,
    input  wire logic              cpu_wake_i,
    input  wire logic              cpu_instr_end_i,
    input  wire logic              cpu_irq_i,
    input  wire logic              cpu_ie_i,
    input  wire logic              int_rst_req_i,
    output logic                   nmi_take_o,
    output logic                   irq_take_o,
    output logic                   core_rst_o,
    output logic [ADDR_W-1:0]      addr_o,
    output logic                   addr_oe_o,
    input  wire logic [ADDR_W-1:0] addr_i,
    output logic [DATA_W-1:0]      data_o,
    output logic                   data_oe_o,
    input  wire logic [DATA_W-1:0] data_i,
    output logic                   mem_access_strobe_n_o,
    output logic                   mem_access_strobe_oe_o,
    input  wire logic              mem_access_strobe_n_i,
    output logic                   io_access_strobe_n_o,
    output logic                   io_access_strobe_oe_o,
    input  wire logic              io_access_strobe_n_i,
    output logic                   rd_n_o,
    output logic                   rd_oe_o,
    output logic                   wr_n_o,
    output logic                   wr_oe_o,
    output logic                   opcode_fetch_flag_o,
    output logic                   opcode_fetch_flag_oe_o,
    input  wire logic              wait_n_i,
    input  wire logic              bus_hold_request_n_i,
    output logic                   bus_hold_grant_n_o,
    output logic                   halt_sleep_flag_n_o,
    input  wire logic              nmi_n_i,
    input  wire logic              rst_pin_i,
    output logic                   rst_pin_o,
    output logic                   rst_pin_oe_o,
    output logic [ADDR_W-1:0]      ext_addr_o,
    output logic                   ext_mem_strobe_n_o,
    output logic                   ext_io_strobe_n_o
);
    localparam logic [`CEBC_RST_CNT_W-1:0] RST_CYC = `CEBC_RST_CNT_W'(`CEBC_RST_DRIVE_CYC);

    cebc_pkg::cebc_bus_state_t s_r;
    cebc_pkg::cebc_bus_state_t s_nxt;
    cebc_int_if                ints ();

    ////////////////////////////////////////////////////////////////////////
    // Bus pins float at reset, grant and halt flag are driven high; the core reset flop holds the machine idle
    localparam cebc_pkg::cebc_bus_state_t S_RST = '{
        state:      cebc_pkg::ST_IDLE,
        mem_access_strobe_n_n:     `CEBC_STROBE_IDLE,
        io_access_strobe_n_n:     `CEBC_STROBE_IDLE,
        rd_n:       `CEBC_STROBE_IDLE,
        wr_n:       `CEBC_STROBE_IDLE,
        bus_hold_grant_n_n:   1'b1,
        halt_n:     1'b1,
        ext_mem_access_strobe_n_n: 1'b1,
        ext_io_access_strobe_n_n: 1'b1,
        core_rst:   1'b1,
        default:    '0
    };

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        // Reset pin: outside low or our own drive resets the core
        if (int_rst_req_i)
        begin
            s_nxt.rst_oe  = 1'b1;
            s_nxt.rst_cnt = RST_CYC;
        end
        else if (s_r.rst_cnt != '0)
        begin
            s_nxt.rst_cnt = s_r.rst_cnt - 1'b1;
        end
        else
        begin
            s_nxt.rst_oe = 1'b0;
        end
        s_nxt.core_rst = ~rst_pin_i | int_rst_req_i;
        // Halt flag: set wins over wake
        if (cpu_halt_i)
            s_nxt.halt_n = 1'b0;
        else if (cpu_wake_i)
            s_nxt.halt_n = 1'b1;
        case (s_r.state)
            cebc_pkg::ST_IDLE:
            begin
                s_nxt.ctl_oe = 1'b1;
                // Hand-off outranks a new CPU cycle
                if (!bus_hold_request_n_i)
                begin
                    s_nxt.ctl_oe = 1'b0;
                    s_nxt.state  = cebc_pkg::ST_FLOAT;
                end
                else if (cpu_req_i && s_r.ctl_oe)
                begin
                    s_nxt.addr    = cpu_addr_i;
                    s_nxt.dout    = cpu_wdata_i;
                    s_nxt.data_oe = cpu_wr_i;
                    s_nxt.mem_access_strobe_n_n  = cpu_io_i;
                    s_nxt.io_access_strobe_n_n  = ~cpu_io_i;
                    s_nxt.rd_n    = cpu_wr_i;
                    s_nxt.wr_n    = ~cpu_wr_i;
                    s_nxt.fetch   = cpu_fetch_i & ~cpu_io_i & ~cpu_wr_i;
                    s_nxt.state   = cebc_pkg::ST_T1;
                end
            end
            cebc_pkg::ST_T1:
                s_nxt.state = cebc_pkg::ST_T2;
            cebc_pkg::ST_T2:
            begin
                // Stretch until the slow party lets go
                if (wait_n_i)
                begin
                    s_nxt.state = cebc_pkg::ST_T3;
                    s_nxt.rdata = data_i;
                end
            end
            cebc_pkg::ST_T3:
            begin
                s_nxt.mem_access_strobe_n_n  = `CEBC_STROBE_IDLE;
                s_nxt.io_access_strobe_n_n  = `CEBC_STROBE_IDLE;
                s_nxt.rd_n    = `CEBC_STROBE_IDLE;
                s_nxt.wr_n    = `CEBC_STROBE_IDLE;
                s_nxt.fetch   = 1'b0;
                s_nxt.data_oe = 1'b0;
                s_nxt.done    = 1'b1;
                s_nxt.state   = cebc_pkg::ST_IDLE;
            end
            cebc_pkg::ST_FLOAT:
            begin
                s_nxt.bus_hold_grant_n_n = 1'b0;
                s_nxt.state    = cebc_pkg::ST_GRANT;
            end
            cebc_pkg::ST_GRANT:
            begin
                s_nxt.ext_addr   = addr_i;
                s_nxt.ext_mem_access_strobe_n_n = mem_access_strobe_n_i;
                s_nxt.ext_io_access_strobe_n_n = io_access_strobe_n_i;
                if (bus_hold_request_n_i)
                begin
                    s_nxt.bus_hold_grant_n_n = 1'b1;
                    s_nxt.state    = cebc_pkg::ST_RESUME;
                end
            end
            cebc_pkg::ST_RESUME:
            begin
                s_nxt.ctl_oe = 1'b1;
                s_nxt.state  = cebc_pkg::ST_IDLE;
            end
            default:
                s_nxt.state = cebc_pkg::ST_IDLE;
        endcase
        // Address, data and strobe pins are released from one cycle after core reset rises until one cycle after it falls; grant and halt flag are driven high
        if (s_r.core_rst)
        begin
            s_nxt.state    = cebc_pkg::ST_IDLE;
            s_nxt.ctl_oe   = 1'b0;
            s_nxt.data_oe  = 1'b0;
            s_nxt.mem_access_strobe_n_n   = `CEBC_STROBE_IDLE;
            s_nxt.io_access_strobe_n_n   = `CEBC_STROBE_IDLE;
            s_nxt.rd_n     = `CEBC_STROBE_IDLE;
            s_nxt.wr_n     = `CEBC_STROBE_IDLE;
            s_nxt.fetch    = 1'b0;
            s_nxt.bus_hold_grant_n_n = 1'b1;
            s_nxt.halt_n   = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            s_r <= S_RST;
        else
            s_r <= s_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    assign ints.nmi_n     = nmi_n_i;
    assign ints.irq       = cpu_irq_i;
    assign ints.ie        = cpu_ie_i;
    assign ints.instr_end = cpu_instr_end_i;

    cebc_nmi_unit u_nmi
    (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .sync_rst_i(s_r.core_rst),
        .ints      (ints.unit)
    );

    assign nmi_take_o             = ints.take_nmi;
    assign irq_take_o             = ints.take_irq;
    assign core_rst_o             = s_r.core_rst;
    assign cpu_done_o             = s_r.done;
    assign cpu_rdata_o            = s_r.rdata;
    assign addr_o                 = s_r.addr;
    assign addr_oe_o              = s_r.ctl_oe;
    assign data_o                 = s_r.dout;
    assign data_oe_o              = s_r.data_oe;
    assign mem_access_strobe_n_o  = s_r.mem_access_strobe_n_n;
    assign mem_access_strobe_oe_o = s_r.ctl_oe;
    assign io_access_strobe_n_o   = s_r.io_access_strobe_n_n;
    assign io_access_strobe_oe_o  = s_r.ctl_oe;
    assign rd_n_o                 = s_r.rd_n;
    assign rd_oe_o                = s_r.ctl_oe;
    assign wr_n_o                 = s_r.wr_n;
    assign wr_oe_o                = s_r.ctl_oe;
    assign opcode_fetch_flag_o    = s_r.fetch;
    assign opcode_fetch_flag_oe_o = s_r.ctl_oe;
    assign bus_hold_grant_n_o     = s_r.bus_hold_grant_n_n;
    assign halt_sleep_flag_n_o    = s_r.halt_n;
    assign rst_pin_o              = s_r.rst_o;
    assign rst_pin_oe_o           = s_r.rst_oe;
    assign ext_addr_o             = s_r.ext_addr;
    assign ext_mem_strobe_n_o     = s_r.ext_mem_access_strobe_n_n;
    assign ext_io_strobe_n_o      = s_r.ext_io_access_strobe_n_n;

    ////////////////////////////////////////////////////////////////////////
    sequence grant_start_s;
        s_r.state == cebc_pkg::ST_IDLE && !bus_hold_request_n_i && !s_r.core_rst;
    endsequence
    sequence floated_then_ack_s;
        !s_r.ctl_oe && s_r.bus_hold_grant_n_n ##1 !s_r.ctl_oe && !s_r.bus_hold_grant_n_n;
    endsequence

    fetch_qualified_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        s_r.fetch |-> !s_r.mem_access_strobe_n_n && !s_r.rd_n && s_r.wr_n)
        else $error("Fetch flag without memory read strobes");

    float_when_granted_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        !s_r.bus_hold_grant_n_n |-> !s_r.ctl_oe && !s_r.data_oe)
        else $error("Outputs driven while bus granted");

    wait_stretch_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (s_r.state == cebc_pkg::ST_T2 && !wait_n_i && !s_r.core_rst) |=> s_r.state == cebc_pkg::ST_T2)
        else $error("Cycle ended while wait held low");

    wait_release_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (s_r.state == cebc_pkg::ST_T2 && wait_n_i && !s_r.core_rst) |=> ##1 s_r.done)
        else $error("Cycle not finished after wait released");

    grant_order_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        grant_start_s |=> floated_then_ack_s)
        else $error("Grant not preceded by floating outputs");

    ext_addr_in_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (s_r.state == cebc_pkg::ST_GRANT && !s_r.core_rst) |=> s_r.ext_addr == $past(addr_i))
        else $error("Master address not taken while granted");

    halt_flag_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (cpu_halt_i && !s_r.core_rst) |=> !s_r.halt_n)
        else $error("Halt indicator not low after halt");

    reset_drive_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        int_rst_req_i |=> s_r.rst_oe && !s_r.rst_o && s_r.core_rst)
        else $error("Internal reset not driven onto pin");

    mem_strobe_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (s_r.state == cebc_pkg::ST_T1) |-> (s_r.mem_access_strobe_n_n != s_r.io_access_strobe_n_n) && (s_r.rd_n != s_r.wr_n))
        else $error("Access strobes not qualified");

    resume_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (s_r.state == cebc_pkg::ST_GRANT && bus_hold_request_n_i && !s_r.core_rst)
        |=> s_r.bus_hold_grant_n_n ##1 s_r.ctl_oe && s_r.state == cebc_pkg::ST_IDLE)
        else $error("Bus not resumed after request release");
endmodule

// ---- design/cebc_map.svh ----
// Constants of the CPU external bus control block
`ifndef CEBC_MAP_SVH
`define CEBC_MAP_SVH
`define CEBC_ADDR_W        24
`define CEBC_DATA_W        8
`define CEBC_CLK_NS        20
`define CEBC_RST_DRIVE_NS  200
`define CEBC_RST_DRIVE_CYC ((`CEBC_RST_DRIVE_NS + `CEBC_CLK_NS - 1) / `CEBC_CLK_NS)
`define CEBC_RST_CNT_W     4
`define CEBC_STROBE_IDLE   1'b1
`endif

// ---- design/cebc_pkg.sv ----
// Types of the CPU external bus control block
`include "cebc_map.svh"
package cebc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_T1, ST_T2, ST_T3, ST_FLOAT, ST_GRANT, ST_RESUME
    } cebc_state_t;

    typedef struct packed {
        cebc_state_t                  state;
        logic [`CEBC_ADDR_W-1:0]      addr;
        logic [`CEBC_DATA_W-1:0]      dout;
        logic [`CEBC_DATA_W-1:0]      rdata;
        logic                         data_oe;
        logic                         ctl_oe;
        logic                         mem_access_strobe_n_n;
        logic                         io_access_strobe_n_n;
        logic                         rd_n;
        logic                         wr_n;
        logic                         fetch;
        logic                         bus_hold_grant_n_n;
        logic                         halt_n;
        logic                         done;
        logic [`CEBC_ADDR_W-1:0]      ext_addr;
        logic                         ext_mem_access_strobe_n_n;
        logic                         ext_io_access_strobe_n_n;
        logic                         rst_oe;
        logic                         rst_o;
        logic [`CEBC_RST_CNT_W-1:0]   rst_cnt;
        logic                         core_rst;
    } cebc_bus_state_t;

    typedef struct packed {
        logic nmi_prev;
        logic pend;
        logic take_nmi;
        logic take_irq;
    } cebc_nmi_state_t;
endpackage

// ---- design/cebc_int_if.sv ----
// Interrupt hand-off between bus control and the NMI unit
`timescale 1ns/100ps
interface cebc_int_if;
    logic nmi_n;
    logic irq;
    logic ie;
    logic instr_end;
    logic take_nmi;
    logic take_irq;
    modport ctrl (output nmi_n, irq, ie, instr_end, input take_nmi, take_irq);
    modport unit (input nmi_n, irq, ie, instr_end, output take_nmi, take_irq);
endinterface

// ---- design/cebc_nmi_unit.sv ----
// NMI edge capture and interrupt priority at instruction end
`timescale 1ns/100ps
module cebc_nmi_unit
(
    input  wire logic  ref_clk_i,
    input  wire logic  arst_n_i,
    input  wire logic  sync_rst_i,
    cebc_int_if.unit   ints
);
    cebc_pkg::cebc_nmi_state_t s_r;
    cebc_pkg::cebc_nmi_state_t s_nxt;
    logic                      fell;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        s_nxt          = s_r;
        fell           = s_r.nmi_prev & ~ints.nmi_n;
        s_nxt.nmi_prev = ints.nmi_n;
        s_nxt.take_nmi = 1'b0;
        s_nxt.take_irq = 1'b0;
        if (ints.instr_end && s_r.pend)
        begin
            s_nxt.take_nmi = 1'b1;
        end
        else if (ints.instr_end && ints.irq && ints.ie)
        begin
            s_nxt.take_irq = 1'b1;
        end
        // A new edge in the taking cycle stays pending
        s_nxt.pend = fell | (s_r.pend & ~(ints.instr_end & s_r.pend));
        if (sync_rst_i)
        begin
            s_nxt = '{nmi_prev: 1'b1, pend: 1'b0, take_nmi: 1'b0, take_irq: 1'b0};
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            s_r <= '{nmi_prev: 1'b1, pend: 1'b0, take_nmi: 1'b0, take_irq: 1'b0};
        else
            s_r <= s_nxt;
    end

    assign ints.take_nmi = s_r.take_nmi;
    assign ints.take_irq = s_r.take_irq;

    ////////////////////////////////////////////////////////////////////////
    nmi_over_irq_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        s_r.take_nmi |-> !s_r.take_irq)
        else $error("NMI and maskable taken together");

    nmi_taken_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (ints.instr_end && s_r.pend && !sync_rst_i) |=> s_r.take_nmi)
        else $error("Pending NMI not taken at instruction end");

    nmi_edge_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ($fell(ints.nmi_n) && !sync_rst_i) |=> s_r.pend || s_r.take_nmi)
        else $error("NMI falling edge not captured");
endmodule

// ---- dv/cebc_far_model.sv ----
// Far side of the bus: slow memory and I/O with wait states, plus an alternate bus master
`timescale 1ns/100ps
module cebc_far_model
(
    input  wire logic        ref_clk_i,
    input  wire logic [23:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        mem_n_i,
    input  wire logic        io_n_i,
    input  wire logic        rd_n_i,
    input  wire logic        wr_n_i,
    input  wire logic        grant_n_i,
    input  wire logic        hold_go_i,
    input  wire logic [1:0]  wait_cyc_i,
    input  wire logic [23:0] m_addr_i,
    output logic [7:0]       rdata_o,
    output logic             wait_n_o,
    output logic             hold_req_n_o,
    output logic [23:0]      m_addr_o,
    output logic             m_mem_n_o
);
    logic [7:0]  mem [logic [23:0]];
    logic [7:0]  io  [logic [23:0]];
    logic        seen = 1'b0;
    logic [1:0]  left = 2'h0;
    logic [23:0] pat  = 24'h5a5a5a;
    logic        act;
    initial {rdata_o, wait_n_o} = 9'h001;
    assign act          = (!mem_n_i || !io_n_i) && (!rd_n_i || !wr_n_i);
    assign hold_req_n_o = !hold_go_i;
    // Master drives its lines only once the grant is seen; otherwise the address floats
    assign m_addr_o     = grant_n_i ? pat : m_addr_i;
    assign m_mem_n_o    = grant_n_i;
    ////////////////////////////////////////////////////////////
    always @(posedge ref_clk_i)
    begin
        #1;
        pat = ~pat;
        // Wait is decided from the count before this edge so that each unit holds one T2 sample low
        wait_n_o = !act || !seen || (left == 2'h0);
        if (!act)
            {seen, left} = 3'h0;
        else if (!seen)
            {seen, left} = {1'b1, wait_cyc_i};
        else if (left != 2'h0)
            left = left - 2'h1;
        if (act && !wr_n_i && !mem_n_i)
            mem[addr_i] = wdata_i;
        if (act && !wr_n_i && !io_n_i)
            io[addr_i] = wdata_i;
        if (act && !rd_n_i)
            rdata_o = !mem_n_i ? (mem.exists(addr_i) ? mem[addr_i] : addr_i[7:0] ^ 8'h3c)
                               : (io.exists(addr_i) ? io[addr_i] : ~addr_i[7:0]);
        else
            rdata_o = ~rdata_o;  // A released data bus must not keep its last value
    end
endmodule

// ---- dv/test_cpu_external_bus_control.sv ----
// Self-checking bench for the CPU external bus control block
`timescale 1ns/100ps
module test_cpu_external_bus_control;
    logic        clk = 1'b0, arst_n = 1'b0, req = 1'b0, io = 1'b0, wr = 1'b0, fe = 1'b0;
    logic        hlt = 1'b0, wak = 1'b0, iend = 1'b0, irq = 1'b0, ie = 1'b0, irr = 1'b0;
    logic        nmi = 1'b1, ext_rst = 1'b1, hold_go = 1'b0;
    logic [1:0]  wcyc = 2'h0;
    logic [23:0] adr = 24'h000000, madr = 24'h000000;
    logic [7:0]  wd = 8'h00;
    logic [31:0] seed = 32'h42355f43;
    int          n_fail = 0, checks_done = 0, cyc = 0, k;
    int unsigned mm [int], im [int];
    wire         done, ntake, itake, crst, aoe, doe, mo, moe, ioo, iooe, rdn, rdoe, wrn, wroe;
    wire         ff, ffoe, grant, hflag, rpo, rpoe, emem, eio, waitn, hreq, mmem;
    wire [7:0]   rdata, dout, pdata;
    wire [23:0]  ao, eadr, maddr;
    // I/O, read and write strobes and reset have pull-ups; the address bus and memory strobe have none
    wire [23:0]  a_w   = aoe ? ao : maddr;
    wire [7:0]   d_w   = doe ? dout : pdata;
    wire         m_w   = moe ? mo : mmem;
    wire         io_w  = iooe ? ioo : 1'b1;
    wire         rd_w  = rdoe ? rdn : 1'b1;
    wire         wr_w  = wroe ? wrn : 1'b1;
    wire         rst_w = (rpoe ? rpo : 1'b1) & ext_rst;
    always #10 clk = ~clk;
    cebc_bus_ctrl cebc_bus_ctrl_inst (
        .ref_clk_i(clk), .arst_n_i(arst_n), .cpu_req_i(req), .cpu_io_i(io), .cpu_wr_i(wr), .cpu_fetch_i(fe),
        .cpu_addr_i(adr), .cpu_wdata_i(wd), .cpu_done_o(done), .cpu_rdata_o(rdata), .cpu_halt_i(hlt),
        .cpu_wake_i(wak), .cpu_instr_end_i(iend), .cpu_irq_i(irq), .cpu_ie_i(ie), .int_rst_req_i(irr),
        .nmi_take_o(ntake), .irq_take_o(itake), .core_rst_o(crst), .addr_o(ao), .addr_oe_o(aoe),
        .addr_i(a_w), .data_o(dout), .data_oe_o(doe), .data_i(d_w), .mem_access_strobe_n_o(mo),
        .mem_access_strobe_oe_o(moe), .mem_access_strobe_n_i(m_w), .io_access_strobe_n_o(ioo),
        .io_access_strobe_oe_o(iooe), .io_access_strobe_n_i(io_w), .rd_n_o(rdn), .rd_oe_o(rdoe),
        .wr_n_o(wrn), .wr_oe_o(wroe), .opcode_fetch_flag_o(ff), .opcode_fetch_flag_oe_o(ffoe),
        .wait_n_i(waitn), .bus_hold_request_n_i(hreq), .bus_hold_grant_n_o(grant),
        .halt_sleep_flag_n_o(hflag), .nmi_n_i(nmi), .rst_pin_i(rst_w), .rst_pin_o(rpo),
        .rst_pin_oe_o(rpoe), .ext_addr_o(eadr), .ext_mem_strobe_n_o(emem), .ext_io_strobe_n_o(eio));
    cebc_far_model cebc_far_model_inst (
        .ref_clk_i(clk), .addr_i(a_w), .wdata_i(d_w), .mem_n_i(m_w), .io_n_i(io_w), .rd_n_i(rd_w),
        .wr_n_i(wr_w), .grant_n_i(grant), .hold_go_i(hold_go), .wait_cyc_i(wcyc), .m_addr_i(madr),
        .rdata_o(pdata), .wait_n_o(waitn), .hold_req_n_o(hreq), .m_addr_o(maddr), .m_mem_n_o(mmem));
    ////////////////////////////////////////////////////////////
    function void step();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task results();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Leaves the request raised so that a following call runs back to back
    task automatic bus(input logic i, input logic w, input logic f, input logic [1:0] ws);
        int unsigned e;
        int          a;
        step();
        adr  = {4'hc, 16'h0000, seed[3:0]};
        a    = int'(adr);
        wd   = seed[15:8];
        {io, wr, fe, wcyc, req} = {i, w, f, ws, 1'b1};
        tick(1);
        chk("mem strobe", 32'(i), 32'(mo));
        chk("io strobe", 32'(!i), 32'(ioo));
        chk("read strobe", 32'(w), 32'(rdn));
        chk("write strobe", 32'(!w), 32'(wrn));
        chk("address", 32'(adr), 32'(ao));
        chk("fetch flag", 32'(f), 32'(ff));
        if (w)
            chk("write data", 32'(wd), 32'(dout));
        for (k = 1; done !== 1'b1 && k < 20; k++) tick(1);
        chk("cycle length", 32'(4 + ws), 32'(k));
        chk("strobes idle", 32'h1, 32'(mo & ioo & rdn & wrn & !ff));
        e = i ? (im.exists(a) ? im[a] : 255 - a % 256) : (mm.exists(a) ? mm[a] : (a % 256) ^ 60);
        if (w && i)
            im[a] = wd;
        else if (w)
            mm[a] = wd;
        else
            chk("read data", e, 32'(rdata));
    endtask
    task automatic take(input logic n, input logic e, input int xn, input int xi);
        int cn;
        int ci;
        {nmi, ie} = {n, e};
        tick(2);
        {cn, ci, iend} = {32'h0, 32'h0, 1'b1};
        repeat (4)
        begin
            tick(1);
            iend = 1'b0;
            cn += int'(ntake === 1'b1);
            ci += int'(itake === 1'b1);
        end
        chk("nmi takes", 32'(xn), 32'(cn));
        chk("irq takes", 32'(xi), 32'(ci));
    endtask
    ////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            results();
        end
    end
    initial
    begin
        tick(5);
        arst_n = 1'b1;
        repeat (10) if (moe !== 1'b1) tick(1);
        tick(1);
        bus(1'b0, 1'b0, 1'b1, 2'h2);
        repeat (16)
        begin
            step();
            bus(seed[16], seed[17], !seed[16] && !seed[17] && seed[18], seed[21:20]);
        end
        req = 1'b0;
        tick(1);
        madr    = seed[23:0];
        hold_go = 1'b1;
        tick(1);
        chk("pins floated", 32'h0, 32'(aoe | moe | iooe | rdoe | wroe | ffoe | doe));
        chk("grant early", 32'h1, 32'(grant));
        tick(1);
        chk("grant", 32'h0, 32'(grant));
        {req, io, wr, fe, wcyc} = 6'h20;
        tick(4);
        chk("ext addr", 32'(madr), 32'(eadr));
        chk("ext strobes", 32'h1, 32'({emem, eio}));
        chk("held off", 32'h0, 32'(done | ffoe | rdoe | wroe));
        hold_go = 1'b0;
        repeat (4) if (grant !== 1'b1) tick(1);
        chk("grant drop", 32'h1, 32'(grant & !aoe & !moe));
        tick(1);
        chk("lines driven", 32'h1, 32'(aoe & moe & rdoe & ffoe));
        repeat (10) if (done !== 1'b1) tick(1);
        chk("queued cycle", 32'h1, 32'(done));
        req = 1'b0;
        irq = 1'b1;
        take(1'b0, 1'b0, 1, 0);
        take(1'b1, 1'b0, 0, 0);
        take(1'b1, 1'b1, 0, 1);
        take(1'b0, 1'b1, 1, 0);
        take(1'b0, 1'b1, 0, 1);
        hlt = 1'b1;
        tick(1);
        hlt = 1'b0;
        tick(2);
        chk("halt flag", 32'h0, 32'(hflag));
        wak = 1'b1;
        tick(1);
        wak = 1'b0;
        tick(2);
        chk("wake", 32'h1, 32'(hflag));
        irr = 1'b1;
        tick(1);
        irr = 1'b0;
        chk("reset drive", 32'h1, 32'(rpoe & !rst_w));
        tick(1);
        chk("core reset", 32'h1, 32'(crst & !moe));
        for (k = 1; rpoe === 1'b1 && k < 20; k++) tick(1);
        chk("drive stretch", 32'h1, 32'(k >= 9 && k <= 11));
        repeat (20) if (moe !== 1'b1) tick(1);
        chk("core released", 32'h0, 32'(crst));
        ext_rst = 1'b0;
        tick(3);
        chk("pin reset", 32'h1, 32'(crst & !moe));
        ext_rst = 1'b1;
        repeat (20) if (moe !== 1'b1) tick(1);
        tick(1);
        bus(1'b0, 1'b0, 1'b1, 2'h1);
        req = 1'b0;
        tick(2);
        results();
    end
endmodule
